// [hdl/dio_pkg.sv]
// constants and types shared by the isolated digital i/o port
package dio_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int unsigned CHANNELS   = 32;
   localparam int unsigned FILT_SEL_W = 4;
   localparam int unsigned FILT_CNT_W = 16;
   localparam int unsigned WIN_LSB    = 5;

   // ***************************************************************
   // register byte offsets inside the 32-byte window
   // ***************************************************************
   localparam logic [4:0] OFS_IN_DATA  = 5'h00;
   localparam logic [4:0] OFS_OUT_DATA = 5'h04;
   localparam logic [4:0] OFS_INT_EN   = 5'h08;
   localparam logic [4:0] OFS_EDGE_SEL = 5'h0C;
   localparam logic [4:0] OFS_INT_STAT = 5'h10;
   localparam logic [4:0] OFS_FILT_CFG = 5'h14;
   localparam logic [4:0] OFS_RAW_IN   = 5'h18;
   localparam logic [4:0] OFS_INT_PEND = 5'h1C;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int unsigned FILT_SEL_LSB = 0;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [31:0] RST_OUT_DATA = 32'h0000_0000;
   localparam logic [31:0] RST_INT_EN   = 32'h0000_0000;
   localparam logic [31:0] RST_EDGE_SEL = 32'h0000_0000;
   localparam logic [31:0] RST_INT_STAT = 32'h0000_0000;
   localparam logic [3:0]  RST_FILT_SEL = 4'h0;
   localparam logic [31:0] RST_LINE_N   = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_LOGIC    = 32'h0000_0000;

   // ***************************************************************
   // register selector
   // ***************************************************************
   typedef enum logic [2:0] {
      DIO_REG_IN_DATA  = 3'b000,
      DIO_REG_OUT_DATA = 3'b001,
      DIO_REG_INT_EN   = 3'b010,
      DIO_REG_EDGE_SEL = 3'b011,
      DIO_REG_INT_STAT = 3'b100,
      DIO_REG_FILT_CFG = 3'b101,
      DIO_REG_RAW_IN   = 3'b110,
      DIO_REG_INT_PEND = 3'b111
   } dio_reg_t;

endpackage

// [hdl/dio_filter.sv]
// per-channel noise and chatter filter for the input lines
`timescale 1ns/1ns
`default_nettype none

module dio_filter (
   // clock and reset
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   // samples and setting
   input  wire logic [dio_pkg::CHANNELS-1:0]        sample,
   input  wire logic [dio_pkg::FILT_SEL_W-1:0]      filt_sel,
   // filtered level
   output logic      [dio_pkg::CHANNELS-1:0]        filtered
);

   typedef struct packed {
      logic [dio_pkg::CHANNELS-1:0][dio_pkg::FILT_CNT_W-1:0] cnt;
      logic [dio_pkg::CHANNELS-1:0]                          level;
   } dio_filt_state_t;

   dio_filt_state_t state;
   dio_filt_state_t next_state;

   // stable time in clocks is two to the power of the setting
   function automatic logic [dio_pkg::FILT_CNT_W-1:0] filt_last(
      input logic [dio_pkg::FILT_SEL_W-1:0] sel);
      logic [dio_pkg::FILT_CNT_W-1:0] lim;
      lim = dio_pkg::FILT_CNT_W'(1) << sel;
      filt_last = lim - dio_pkg::FILT_CNT_W'(1);
   endfunction

   // a change is taken only once it has held for the whole stable time
   always_comb begin
      next_state = state;
      for (int i = 0; i < dio_pkg::CHANNELS; i++) begin
         if (sample[i] == state.level[i]) begin
            next_state.cnt[i] = '0;
         end else if (state.cnt[i] >= filt_last(filt_sel)) begin
            next_state.level[i] = sample[i];
            next_state.cnt[i]   = '0;
         end else begin
            next_state.cnt[i] = state.cnt[i] + dio_pkg::FILT_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.cnt   <= '0;
         state.level <= dio_pkg::RST_LOGIC;
      end else begin
         state <= next_state;
      end
   end

   assign filtered = state.level;

endmodule

`default_nettype wire

// [hdl/dio_port.sv]
// isolated digital input and open-collector output port with interrupts
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - 32 isolated inputs, each usable as an interrupt source
// - negative logic: data 0 is high line, data 1 is low line
// - 32 writable open-collector outputs, sinking while data bit is 1
// - per-bit interrupt enable; disabled bits never raise the request
// - per-bit trigger edge: logical rising or logical falling
// - all input interrupts merged onto one interrupt line
// - software-configured noise filter on every input
// - host reaches data, interrupt and filter controls over the bus
module dio_port (
   // clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // window placement from configuration
   input  wire logic [31:dio_pkg::WIN_LSB]     window_base,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [31:0]                    paddr,
   input  wire logic [31:0]                    pwdata,
   input  wire logic [3:0]                     pstrb,
   output logic                                pready,
   output logic      [31:0]                    prdata,
   output logic                                pslverr,
   // field input lines, low means data 1
   input  wire logic [dio_pkg::CHANNELS-1:0]   in_line,
   // open-collector outputs
   output logic      [dio_pkg::CHANNELS-1:0]   out_line,
   output logic      [dio_pkg::CHANNELS-1:0]   out_line_oe,
   // merged interrupt request
   output logic                                irq
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [dio_pkg::CHANNELS-1:0]   sync1;
      logic [dio_pkg::CHANNELS-1:0]   sync2;
      logic [dio_pkg::CHANNELS-1:0]   prev;
      logic [dio_pkg::CHANNELS-1:0]   out_data;
      logic [dio_pkg::CHANNELS-1:0]   int_en;
      logic [dio_pkg::CHANNELS-1:0]   edge_sel;
      logic [dio_pkg::CHANNELS-1:0]   int_stat;
      logic [dio_pkg::FILT_SEL_W-1:0] filt_sel;
      logic                           ready;
      logic [31:0]                    rdata;
      logic                           slverr;
      logic                           irq;
   } dio_state_t;

   dio_state_t state;
   dio_state_t next_state;

   logic [dio_pkg::CHANNELS-1:0] filtered;
   logic [dio_pkg::CHANNELS-1:0] raw_logic;
   logic [dio_pkg::CHANNELS-1:0] rise;
   logic [dio_pkg::CHANNELS-1:0] fall;
   logic [dio_pkg::CHANNELS-1:0] event_hit;
   logic [dio_pkg::CHANNELS-1:0] w1c;
   logic [dio_pkg::CHANNELS-1:0] next_pend;
   logic                         in_window;
   logic                         aligned;
   logic                         access;
   logic                         commit;
   logic                         wr_commit;
   dio_pkg::dio_reg_t            sel;

   // ***************************************************************
   // helpers
   // ***************************************************************

   // register selector from the offset inside the window
   function automatic dio_pkg::dio_reg_t reg_decode(input logic [4:0] ofs);
      case (ofs)
         dio_pkg::OFS_IN_DATA:  reg_decode = dio_pkg::DIO_REG_IN_DATA;
         dio_pkg::OFS_OUT_DATA: reg_decode = dio_pkg::DIO_REG_OUT_DATA;
         dio_pkg::OFS_INT_EN:   reg_decode = dio_pkg::DIO_REG_INT_EN;
         dio_pkg::OFS_EDGE_SEL: reg_decode = dio_pkg::DIO_REG_EDGE_SEL;
         dio_pkg::OFS_INT_STAT: reg_decode = dio_pkg::DIO_REG_INT_STAT;
         dio_pkg::OFS_FILT_CFG: reg_decode = dio_pkg::DIO_REG_FILT_CFG;
         dio_pkg::OFS_RAW_IN:   reg_decode = dio_pkg::DIO_REG_RAW_IN;
         dio_pkg::OFS_INT_PEND: reg_decode = dio_pkg::DIO_REG_INT_PEND;
         default:               reg_decode = dio_pkg::DIO_REG_INT_PEND;
      endcase
   endfunction

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_val,
      input logic [31:0] wdata,
      input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // ***************************************************************
   // input filter
   // ***************************************************************
   dio_filter u_filter (
      .pclk     (pclk),
      .presetn  (presetn),
      .sample   (raw_logic),
      .filt_sel (state.filt_sel),
      .filtered (filtered)
   );

   // ***************************************************************
   // bus decode
   // ***************************************************************
   always_comb begin
      raw_logic = ~state.sync2;
      in_window = (paddr[31:dio_pkg::WIN_LSB] == window_base);
      aligned   = (paddr[1:0] == 2'h0);
      access    = psel && penable;
      commit    = access && state.ready;
      wr_commit = commit && pwrite && in_window && aligned;
      sel       = reg_decode(paddr[4:0]);
   end

   // ***************************************************************
   // edge detection and events
   // ***************************************************************
   always_comb begin
      rise      = filtered & ~state.prev;
      fall      = ~filtered & state.prev;
      // 1 selects logical rising, i.e. line high to low
      event_hit = (state.edge_sel & rise)
                | (~state.edge_sel & fall);
      w1c       = '0;
      if (wr_commit && sel == dio_pkg::DIO_REG_INT_STAT) begin
         w1c = lane_merge('0, pwdata, pstrb);
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_state = state;

      // two-flop synchroniser on the field lines
      next_state.sync1 = in_line;
      next_state.sync2 = state.sync1;
      next_state.prev  = filtered;

      // a new event wins over a clear in the same cycle
      next_state.int_stat = (state.int_stat & ~w1c) | event_hit;

      // register writes at the completing edge only
      if (wr_commit) begin
         case (sel)
            dio_pkg::DIO_REG_OUT_DATA: begin
               next_state.out_data = lane_merge(state.out_data, pwdata,
                                                pstrb);
            end
            dio_pkg::DIO_REG_INT_EN: begin
               next_state.int_en = lane_merge(state.int_en, pwdata,
                                              pstrb);
            end
            dio_pkg::DIO_REG_EDGE_SEL: begin
               next_state.edge_sel = lane_merge(state.edge_sel, pwdata,
                                                pstrb);
            end
            dio_pkg::DIO_REG_FILT_CFG: begin
               if (pstrb[0]) begin
                  next_state.filt_sel = pwdata[dio_pkg::FILT_SEL_LSB +:
                                               dio_pkg::FILT_SEL_W];
               end
            end
            default: begin
               next_state.filt_sel = state.filt_sel;
            end
         endcase
      end

      // merged level request, gated by the enables
      next_pend      = next_state.int_stat & next_state.int_en;
      next_state.irq = |next_pend;

      // one wait state: ready rises in the second access cycle
      next_state.ready  = 1'b0;
      next_state.slverr = 1'b0;
      next_state.rdata  = '0;
      if (access && !state.ready) begin
         next_state.ready  = 1'b1;
         next_state.slverr = !(in_window && aligned);
         if (!pwrite && in_window && aligned) begin
            case (sel)
               dio_pkg::DIO_REG_IN_DATA:  next_state.rdata = filtered;
               dio_pkg::DIO_REG_OUT_DATA: next_state.rdata = state.out_data;
               dio_pkg::DIO_REG_INT_EN:   next_state.rdata = state.int_en;
               dio_pkg::DIO_REG_EDGE_SEL: next_state.rdata = state.edge_sel;
               dio_pkg::DIO_REG_INT_STAT: next_state.rdata = state.int_stat;
               dio_pkg::DIO_REG_FILT_CFG: begin
                  next_state.rdata[dio_pkg::FILT_SEL_LSB +:
                                   dio_pkg::FILT_SEL_W] = state.filt_sel;
               end
               dio_pkg::DIO_REG_RAW_IN:   next_state.rdata = raw_logic;
               dio_pkg::DIO_REG_INT_PEND: begin
                  next_state.rdata = state.int_stat & state.int_en;
               end
               default:                   next_state.rdata = '0;
            endcase
         end
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.sync1    <= dio_pkg::RST_LINE_N;
         state.sync2    <= dio_pkg::RST_LINE_N;
         state.prev     <= dio_pkg::RST_LOGIC;
         state.out_data <= dio_pkg::RST_OUT_DATA;
         state.int_en   <= dio_pkg::RST_INT_EN;
         state.edge_sel <= dio_pkg::RST_EDGE_SEL;
         state.int_stat <= dio_pkg::RST_INT_STAT;
         state.filt_sel <= dio_pkg::RST_FILT_SEL;
         state.ready    <= 1'b0;
         state.rdata    <= '0;
         state.slverr   <= 1'b0;
         state.irq      <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   always_comb begin
      pready      = state.ready;
      prdata      = state.rdata;
      pslverr     = state.slverr;
      out_line    = '0;  // the stage only ever pulls low
      out_line_oe = state.out_data;
      irq         = state.irq;
   end

endmodule

`default_nettype wire

// [tb/dio_port_monitor.sv]
// bus, output and interrupt checker for the digital i/o port
`timescale 1ns/1ns
`default_nettype none
module dio_port_monitor (
   // clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // bus side
   input wire logic [31:dio_pkg::WIN_LSB]   window_base,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [31:0]                  paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic                         pready,
   input wire logic [31:0]                  prdata,
   input wire logic                         pslverr,
   // field side
   input wire logic [dio_pkg::CHANNELS-1:0] out_line,
   input wire logic [dio_pkg::CHANNELS-1:0] out_line_oe,
   input wire logic                         irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_out_write;
      psel && penable && pready && pwrite && pstrb == 4'hF
         && paddr == {window_base, dio_pkg::OFS_OUT_DATA};
   endsequence
   a_ready_follows: assert property (s_access |=> pready)
      else $error("pready not one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (
      pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_window: assert property ((s_access and
      paddr[31:dio_pkg::WIN_LSB] != window_base) |=> pslverr)
      else $error("outside access not refused");
   a_err_align: assert property ((s_access and
      paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unaligned access not refused");
   a_err_flag: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_out_open: assert property (out_line == 32'h0)
      else $error("open-collector value not low");
   a_out_write: assert property (s_out_write
      |=> out_line_oe == $past(pwdata))
      else $error("output write not applied");
   a_oe_hold: assert property (!$stable(out_line_oe)
      |-> $past(pready && pwrite))
      else $error("outputs changed without write");
   a_irq_fall: assert property ($fell(irq)
      |-> $past(pready && pwrite))
      else $error("interrupt dropped without write");
endmodule
bind dio_port dio_port_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .window_base(window_base), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .out_line(out_line), .out_line_oe(out_line_oe), .irq(irq));
`default_nettype wire

// [tb/dio_field_model.sv]
// field wiring: contacts on the inputs, pulled-up loads on the outputs
`timescale 1ns/1ns
`default_nettype none
module dio_field_model (
   // logical contact state
   input  wire logic [dio_pkg::CHANNELS-1:0] contact,
   // lines toward the port
   output logic      [dio_pkg::CHANNELS-1:0] in_line,
   input  wire logic [dio_pkg::CHANNELS-1:0] out_line,
   input  wire logic [dio_pkg::CHANNELS-1:0] out_line_oe,
   // load level seen behind each output
   output logic      [dio_pkg::CHANNELS-1:0] load_level
);
   assign in_line = ~contact;
   always_comb begin
      for (int i = 0; i < dio_pkg::CHANNELS; i++) begin
         load_level[i] = out_line_oe[i] ? out_line[i] : 1'b1;
      end
   end
endmodule
`default_nettype wire

// [tb/test_dio_port.sv]
// self-checking bench for the digital i/o port
`timescale 1ns/1ns
`default_nettype none
module test_dio_port;
   localparam logic [31:5] BASE = 27'h0123456;
   localparam logic [31:5] BASE2 = 27'h0654321;
   localparam logic [31:0] R_IN = {BASE, dio_pkg::OFS_IN_DATA};
   localparam logic [31:0] R_OUT = {BASE, dio_pkg::OFS_OUT_DATA};
   localparam logic [31:0] R_EN = {BASE, dio_pkg::OFS_INT_EN};
   localparam logic [31:0] R_EDGE = {BASE, dio_pkg::OFS_EDGE_SEL};
   localparam logic [31:0] R_STAT = {BASE, dio_pkg::OFS_INT_STAT};
   localparam logic [31:0] R_FILT = {BASE, dio_pkg::OFS_FILT_CFG};
   localparam logic [31:0] R_RAW = {BASE, dio_pkg::OFS_RAW_IN};
   localparam logic [31:0] R_PEND = {BASE, dio_pkg::OFS_INT_PEND};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        er;
   logic [31:5] base;
   logic [3:0]  pstrb;
   logic [31:0] paddr, pwdata, prdata, contact, in_line, rd;
   logic [31:0] out_line, out_line_oe, load_level;
   int          n_mismatch, num_checks;
   always #2 pclk = ~pclk;
   dio_port DUT (.pclk(pclk), .presetn(presetn), .window_base(base),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .in_line(in_line), .out_line(out_line),
      .out_line_oe(out_line_oe), .irq(irq));
   dio_field_model u_field (.contact(contact), .in_line(in_line),
      .out_line(out_line), .out_line_oe(out_line_oe),
      .load_level(load_level));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer; ends on the edge where pready was seen
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(rd, exp);
   endtask
   task automatic wait_irq(input logic e);
      for (int k = 0; k < 64 && irq !== e; k++) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, e});
      if (irq !== e) stop_test();
   endtask
   task automatic t_reset();
      for (int r = 0; r < 8; r++) rdc(R_IN + 4 * r, 32'h0);
      chk(load_level, 32'hFFFF_FFFF);
      $display("reset test done");
   endtask
   task automatic t_output();
      wr(R_OUT, 32'hA5A5_0F0F);
      rdc(R_OUT, 32'hA5A5_0F0F);
      chk(load_level, 32'h5A5A_F0F0);
      bus(1'b1, R_OUT, 32'hFFFF_FFFF, 4'h2);
      rdc(R_OUT, 32'hA5A5_FF0F);
      wr(R_IN, 32'hFFFF_FFFF);
      rdc(R_IN, 32'h0);
      wr(R_OUT + 32, 32'h0);
      chk({31'h0, er}, 32'h1);
      rdc(R_OUT + 2, 32'h0);
      chk({31'h0, er}, 32'h1);
      rdc(R_OUT, 32'hA5A5_FF0F);
      // move the window and reach the port only at its new place
      base <= BASE2;
      wr({BASE2, dio_pkg::OFS_OUT_DATA}, 32'h0000_00C3);
      rdc({BASE2, dio_pkg::OFS_OUT_DATA}, 32'h0000_00C3);
      rdc(R_OUT, 32'h0);
      chk({31'h0, er}, 32'h1);
      base <= BASE;
      rdc(R_OUT, 32'h0000_00C3);
      chk({31'h0, er}, 32'h0);
      wr(R_OUT, 32'h0);
      $display("output test done");
   endtask
   task automatic t_irq();
      wr(R_EDGE, 32'h1);
      wr(R_EN, 32'h3);
      contact <= 32'h3;
      wait_irq(1'b1);
      rdc(R_STAT, 32'h1);
      rdc(R_IN, 32'h3);
      rdc(R_RAW, 32'h3);
      rdc(R_PEND, 32'h1);
      wr(R_STAT, 32'h1);
      wait_irq(1'b0);
      contact <= 32'h0;
      wait_irq(1'b1);
      rdc(R_STAT, 32'h2);
      wr(R_EN, 32'h0);
      wait_irq(1'b0);
      rdc(R_PEND, 32'h0);
      wr(R_EN, 32'h2);
      wait_irq(1'b1);
      wr(R_STAT, 32'hFFFF_FFFF);
      wait_irq(1'b0);
      wr(R_EDGE, 32'hFFFF_FFFF);
      wr(R_EN, 32'hFFFF_FFFF);
      contact <= 32'hFFFF_FFFF;
      wait_irq(1'b1);
      rdc(R_STAT, 32'hFFFF_FFFF);
      wr(R_STAT, 32'hFFFF_FFFF);
      contact <= 32'h0;
      wait_irq(1'b0);
      repeat (8) @(posedge pclk);
      rdc(R_STAT, 32'h0);
      $display("interrupt test done");
   endtask
   task automatic t_filter();
      wr(R_FILT, 32'h2);
      wr(R_EDGE, 32'h8);
      wr(R_EN, 32'h8);
      contact <= 32'h8;
      repeat (2) @(posedge pclk);
      contact <= 32'h0;
      repeat (24) @(posedge pclk);
      rdc(R_STAT, 32'h0);
      rdc(R_FILT, 32'h2);
      contact <= 32'h8;
      wait_irq(1'b1);
      rdc(R_STAT, 32'h8);
      $display("filter test done");
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      contact = 32'h0;
      base = BASE;
      n_mismatch = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_output();
      t_irq();
      t_filter();
      stop_test();
   end
endmodule
`default_nettype wire
